// File: lps_fsm.sv
// Functional notes
// - Per-port enable switches automatic power saving on
// - Enabled controller is low, wake or normal
// - Low and wake alternate until energy, default 2s
// - Detected energy moves controller to normal
// - Autoneg link failure times out back to low
// - Reset starts controller in low power
// - Forced speed from low: normal then stays
// - Autoneg off in normal: link drop stays normal
// - Low powers down blocks, management stays alive
// - Low state watches media energy for wake
// - Two-bit field selects sleep dwell time
// - Sleep randomized from minus 80 to plus 60 ms
// - Wake sends up to three bursts, pairs alternate
// - Wake returns to low after sending energy
// - Management port stays powered during wake
// - Two bits select link-status timeout
// - Manual power-down bit works independently
// - Autoneg enable bit steers the machine
// - Link status bit gives link up or failure
module lps_fsm
  import lps_pkg::*;
#(
  parameter int unsigned       MS_CYC   = LPS_MS_CYC,
  parameter logic [3:0][15:0]  SLEEP_MS = LPS_SLEEP_MS_DEF,
  parameter logic [3:0][15:0]  WAKE_MS  = LPS_WAKE_MS_DEF,
  parameter logic [3:0][15:0]  TMO_MS   = LPS_TMO_MS_DEF,
  parameter logic [15:0]       SEED     = LPS_SEED_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        apm_en_i,
  input  wire logic        an_en_i,
  input  wire logic        link_up_i,
  input  wire logic        energy_i,
  input  wire logic [1:0]  sleep_sel_i,
  input  wire logic [1:0]  wake_sel_i,
  input  wire logic        tmo_sel_hi_i,
  input  wire logic        tmo_sel_lo_i,
  input  wire logic        pwr_down_i,
  output logic [1:0]       state_o,
  output logic             blocks_pd_o,
  output logic             mgmt_on_o,
  output logic             flp_burst_o,
  output logic             flp_pair_b_o
);

  typedef struct packed {
    logic        e_s1;
    logic        e_s2;
    lps_state_t  st;
    logic        locked;
    logic [15:0] ms_cnt;
    logic [15:0] tmr;
    logic [7:0]  wk_ms;
    logic [1:0]  burst_n;
    logic        flp_burst;
    logic        flp_pair_b;
    logic        pd;
    logic        mgmt_on;
  } lps_fsm_st_t;

  localparam lps_fsm_st_t LPS_RST = '{
    e_s1:       1'b0,
    e_s2:       1'b0,
    st:         LPS_LOW,
    locked:     1'b0,
    ms_cnt:     16'h0000,
    tmr:        LPS_SLEEP_RST_MS,
    wk_ms:      8'h00,
    burst_n:    2'h0,
    flp_burst:  1'b0,
    flp_pair_b: 1'b0,
    pd:         1'b1,
    mgmt_on:    1'b1
  };

  lps_fsm_st_t q;
  lps_fsm_st_t d;
  logic        tick;
  logic [1:0]  tmo_sel;

  lps_rnd_if rnd_if ();

  lps_prng #(
    .SEED (SEED)
  ) u_prng (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .rnd       (rnd_if.src)
  );

  // Programmed sleep plus random offset, never below one ms
  function automatic logic [15:0] sleep_len(input logic [15:0] base,
                                            input logic [7:0]  r);
    logic [16:0] sum;
    sum = {1'b0, base} + {9'h000, r};
    if (sum <= {9'h000, LPS_OFS_NEG_MS}) begin
      sleep_len = 16'h0001;
    end else begin
      sleep_len = 16'(sum - {9'h000, LPS_OFS_NEG_MS});
    end
  endfunction

  assign tmo_sel = {tmo_sel_hi_i, tmo_sel_lo_i};

  always_comb begin
    d = q;
    // Energy from the analog detector passes two flops (e_s1, e_s2) before use
    d.e_s1 = energy_i;
    d.e_s2 = q.e_s1;
    d.flp_burst = 1'b0;
    tick = (q.ms_cnt == 16'(MS_CYC - 1));
    d.ms_cnt = tick ? 16'h0000 : q.ms_cnt + 16'h0001;
    case (q.st)
      LPS_OFF: begin
        if (apm_en_i) begin
          d.st = LPS_NORMAL;
          d.locked = !an_en_i;
          d.tmr = TMO_MS[tmo_sel];
        end
      end
      LPS_LOW: begin
        if (!apm_en_i) begin
          d.st = LPS_OFF;
        end else if (q.e_s2) begin
          d.st = LPS_NORMAL;
          d.locked = !an_en_i;
          d.tmr = TMO_MS[tmo_sel];
        end else if (tick) begin
          if (q.tmr <= 16'h0001) begin
            d.st = LPS_WAKE;
            d.tmr = WAKE_MS[wake_sel_i];
            d.wk_ms = 8'h00;
            d.burst_n = 2'h1;
            d.flp_burst = 1'b1;
            d.flp_pair_b = 1'b0;
          end else begin
            d.tmr = q.tmr - 16'h0001;
          end
        end
      end
      LPS_WAKE: begin
        if (!apm_en_i) begin
          d.st = LPS_OFF;
        end else if (q.e_s2) begin
          d.st = LPS_NORMAL;
          d.locked = !an_en_i;
          d.tmr = TMO_MS[tmo_sel];
        end else if (tick) begin
          if (q.tmr <= 16'h0001) begin
            // Fresh random draw per sleep, keeps two peers from locking step
            d.st = LPS_LOW;
            d.tmr = sleep_len(SLEEP_MS[sleep_sel_i], rnd_if.val);
          end else begin
            d.tmr = q.tmr - 16'h0001;
            if (q.wk_ms == LPS_BURST_GAP_MS - 8'h01) begin
              d.wk_ms = 8'h00;
              if (q.burst_n < LPS_MAX_BURSTS) begin
                d.burst_n = q.burst_n + 2'h1;
                d.flp_burst = 1'b1;
                d.flp_pair_b = !q.flp_pair_b;
              end
            end else begin
              d.wk_ms = q.wk_ms + 8'h01;
            end
          end
        end
      end
      LPS_NORMAL: begin
        if (!apm_en_i) begin
          d.st = LPS_OFF;
        end else begin
          if (!an_en_i) begin
            d.locked = 1'b1;
          end
          if (link_up_i) begin
            d.tmr = TMO_MS[tmo_sel];
          end else if (an_en_i && !q.locked && tick) begin
            if (q.tmr <= 16'h0001) begin
              d.st = LPS_LOW;
              d.tmr = sleep_len(SLEEP_MS[sleep_sel_i], rnd_if.val);
            end else begin
              d.tmr = q.tmr - 16'h0001;
            end
          end
        end
      end
      default: begin
        d.st = LPS_LOW;
      end
    endcase
    if (d.st != LPS_NORMAL) begin
      d.locked = 1'b0;
    end
    // Manual power-down acts with or without power saving
    d.pd = (d.st == LPS_LOW) || pwr_down_i;
    // Management port is never gated, in any state
    d.mgmt_on = 1'b1;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= LPS_RST;
    end else begin
      q <= d;
    end
  end

  assign state_o      = q.st;
  assign blocks_pd_o  = q.pd;
  assign mgmt_on_o    = q.mgmt_on;
  assign flp_burst_o  = q.flp_burst;
  assign flp_pair_b_o = q.flp_pair_b;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_rst_low;
    $fell(sys_rst_i) |-> q.st == LPS_LOW;
  endproperty
  a_rst_low: assert property (p_rst_low)
    else $error("not in low power after reset");

  property p_three_states;
    apm_en_i && $past(apm_en_i) |-> q.st != LPS_OFF;
  endproperty
  a_three_states: assert property (p_three_states)
    else $error("enabled controller outside its three states");

  property p_energy_normal;
    apm_en_i && q.e_s2 && (q.st == LPS_LOW || q.st == LPS_WAKE)
      |=> q.st == LPS_NORMAL;
  endproperty
  a_energy_normal: assert property (p_energy_normal)
    else $error("energy did not bring normal state");

  property p_locked_stays;
    apm_en_i && q.st == LPS_NORMAL && q.locked ##1 apm_en_i
      |-> q.st == LPS_NORMAL;
  endproperty
  a_locked_stays: assert property (p_locked_stays)
    else $error("locked normal state left");

  property p_an_off_locks;
    apm_en_i && q.st == LPS_NORMAL && !an_en_i ##1 apm_en_i
      |-> q.locked && q.st == LPS_NORMAL;
  endproperty
  a_an_off_locks: assert property (p_an_off_locks)
    else $error("autoneg off did not lock normal");

  property p_timeout_low;
    apm_en_i && q.st == LPS_NORMAL && an_en_i && !q.locked && !link_up_i
      && tick && q.tmr <= 16'h0001 |=> q.st == LPS_LOW;
  endproperty
  a_timeout_low: assert property (p_timeout_low)
    else $error("link timeout did not return to low");

  property p_pd_low;
    q.st == LPS_LOW |-> q.pd;
  endproperty
  a_pd_low: assert property (p_pd_low)
    else $error("blocks awake in low power");

  property p_manual_pd;
    pwr_down_i |=> blocks_pd_o;
  endproperty
  a_manual_pd: assert property (p_manual_pd)
    else $error("manual power-down ignored");

  property p_mgmt_on;
    1'b1 |-> mgmt_on_o;
  endproperty
  a_mgmt_on: assert property (p_mgmt_on)
    else $error("management port powered down");

  property p_burst_max;
    q.flp_burst |-> q.burst_n <= LPS_MAX_BURSTS && q.st == LPS_WAKE;
  endproperty
  a_burst_max: assert property (p_burst_max)
    else $error("burst outside wake or over count");

  property p_wake_entry_burst;
    $changed(q.st) && q.st == LPS_WAKE |-> q.flp_burst && !q.flp_pair_b;
  endproperty
  a_wake_entry_burst: assert property (p_wake_entry_burst)
    else $error("wake entered without first burst on pair A");

  property p_sleep_load;
    $past(q.st) == LPS_WAKE && q.st == LPS_LOW
      |-> q.tmr >= 16'h0001;
  endproperty
  a_sleep_load: assert property (p_sleep_load)
    else $error("sleep timer loaded with zero");

  // Timers count down only on a tick, so the two expiry checks below are sampled there
  property p_off_disabled;
    !apm_en_i |=> q.st == LPS_OFF;
  endproperty
  a_off_disabled: assert property (p_off_disabled)
    else $error("disabled controller not off");

  property p_low_to_wake;
    apm_en_i && q.st == LPS_LOW && !q.e_s2 && tick && q.tmr <= 16'h0001
      |=> q.st == LPS_WAKE && q.flp_burst;
  endproperty
  a_low_to_wake: assert property (p_low_to_wake)
    else $error("sleep expiry did not start wake");

  property p_wake_to_low;
    apm_en_i && q.st == LPS_WAKE && !q.e_s2 && tick && q.tmr <= 16'h0001
      |=> q.st == LPS_LOW;
  endproperty
  a_wake_to_low: assert property (p_wake_to_low)
    else $error("wake expiry did not return to low");

  property p_link_reload;
    apm_en_i && q.st == LPS_NORMAL && link_up_i
      |=> q.tmr == TMO_MS[$past(tmo_sel)];
  endproperty
  a_link_reload: assert property (p_link_reload)
    else $error("link up did not reload timeout");

  property p_sleep_window;
    $past(q.st) == LPS_WAKE && q.st == LPS_LOW
      |-> q.tmr <= $past(SLEEP_MS[sleep_sel_i]) + 16'(LPS_OFS_POS_MS)
        && q.tmr + 16'(LPS_OFS_NEG_MS) >= $past(SLEEP_MS[sleep_sel_i]);
  endproperty
  a_sleep_window: assert property (p_sleep_window)
    else $error("sleep time outside offset window");

  property p_pair_alt;
    q.flp_burst |-> q.flp_pair_b == !q.burst_n[0];
  endproperty
  a_pair_alt: assert property (p_pair_alt)
    else $error("burst pair not alternating");

  c_locked: cover property (q.st == LPS_NORMAL && q.locked && !link_up_i);
  c_wake: cover property (q.st == LPS_LOW ##1 q.st == LPS_WAKE);
  c_low_norm: cover property (q.st == LPS_LOW ##1 q.st == LPS_NORMAL);
  c_tmo: cover property (q.st == LPS_NORMAL ##1 q.st == LPS_LOW);
  c_three: cover property (q.flp_burst && q.burst_n == LPS_MAX_BURSTS);

endmodule

// File: lps_pkg.sv
package lps_pkg;

  // Controller states, Gray along low -> wake -> normal
  typedef enum logic [1:0] {
    LPS_LOW    = 2'b00,
    LPS_WAKE   = 2'b01,
    LPS_NORMAL = 2'b11,
    LPS_OFF    = 2'b10
  } lps_state_t;

  // Clock and millisecond timebase
  localparam int unsigned LPS_CLK_NS = 50;
  localparam int unsigned LPS_MS_NS  = 1000000;
  localparam int unsigned LPS_MS_CYC = LPS_MS_NS / LPS_CLK_NS;

  // Duration tables in ms, index = two-bit select field
  localparam logic [3:0][15:0] LPS_SLEEP_MS_DEF = {16'h0FA0, 16'h0BB8, 16'h07D0, 16'h03E8};
  localparam logic [3:0][15:0] LPS_WAKE_MS_DEF  = {16'h0320, 16'h0190, 16'h00C8, 16'h0064};
  localparam logic [3:0][15:0] LPS_TMO_MS_DEF   = {16'h07D0, 16'h05DC, 16'h03E8, 16'h01F4};

  // Sleep counter value after reset (two seconds)
  localparam logic [15:0] LPS_SLEEP_RST_MS = 16'h07D0;

  // Random sleep offset window: -80 ms .. +60 ms
  localparam logic [7:0] LPS_OFS_NEG_MS = 8'h50;
  localparam logic [7:0] LPS_OFS_POS_MS = 8'h3C;
  localparam logic [7:0] LPS_OFS_SPAN   = LPS_OFS_NEG_MS + LPS_OFS_POS_MS + 8'h01;

  // Wake-up pulse bursts
  localparam logic [1:0] LPS_MAX_BURSTS = 2'h3;
  localparam logic [7:0] LPS_BURST_GAP_MS = 8'h10;

  // Pseudo-random source
  localparam logic [15:0] LPS_SEED_DEF = 16'hACE1;

endpackage

// File: lps_rnd_if.sv
interface lps_rnd_if;
  logic [7:0] val;
  modport src (output val);
  modport snk (input  val);
endinterface

// File: lps_prng.sv
module lps_prng
  import lps_pkg::*;
#(
  parameter logic [15:0] SEED = LPS_SEED_DEF
) (
  input  wire logic  clk_i,
  input  wire logic  sys_rst_i,
  lps_rnd_if.src     rnd
);

  typedef struct packed {
    logic [15:0] lfsr;
    logic [7:0]  val;
  } lps_prng_st_t;

  lps_prng_st_t q;
  lps_prng_st_t d;

  // Free running, so the value drawn depends on when the draw happens
  always_comb begin
    d = q;
    d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
    // Fold into 0..span-1; one subtract is enough for an 8-bit value
    if (q.lfsr[7:0] >= LPS_OFS_SPAN) begin
      d.val = q.lfsr[7:0] - LPS_OFS_SPAN;
    end else begin
      d.val = q.lfsr[7:0];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '{lfsr: SEED, val: 8'h00};
    end else begin
      q <= d;
    end
  end

  assign rnd.val = q.val;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_rnd_range;
    1'b1 |-> rnd.val < LPS_OFS_SPAN;
  endproperty
  a_rnd_range: assert property (p_rnd_range)
    else $error("random offset out of range");

  property p_lfsr_alive;
    q.lfsr != 16'h0000;
  endproperty
  a_lfsr_alive: assert property (p_lfsr_alive)
    else $error("random source stuck at zero");

endmodule

// File: lps_partner.sv
module lps_partner (
  input  wire logic clk_i,
  input  wire logic burst_i,
  input  wire logic present_i,
  output logic      energy_o,
  output logic      link_up_o
);
  // Idle peer: speaks only after hearing a burst, so a deaf wake shows up
  always_ff @(posedge clk_i) begin
    if (!present_i) begin
      energy_o  <= 1'b0;
      link_up_o <= 1'b0;
    end else if (burst_i) begin
      energy_o <= 1'b1;
    end else if (energy_o) begin
      link_up_o <= 1'b1;
    end
  end
endmodule

// File: link_energy_power_save_fsm_bench.sv
module link_energy_power_save_fsm_bench
  import lps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) fail_at(g, e); end
  localparam int MSC = 4;
  logic       clk_i        = 1'b0;
  logic       sys_rst_i    = 1'b1;
  logic       apm_en_i     = 1'b1;
  logic       an_en_i      = 1'b1;
  logic       present      = 1'b0;
  logic       pwr_down_i   = 1'b0;
  logic [1:0] sleep_sel_i  = 2'h0;
  logic [1:0] wake_sel_i   = 2'h0;
  logic       tmo_sel_hi_i = 1'b0;
  logic       tmo_sel_lo_i = 1'b0;
  logic       energy_i;
  logic       link_up_i;
  logic [1:0] state_o;
  logic       blocks_pd_o;
  logic       mgmt_on_o;
  logic       flp_burst_o;
  logic       flp_pair_b_o;
  int         err_count    = 0;
  int         check_count  = 0;

  always #25 clk_i = ~clk_i;

  lps_fsm #(.MS_CYC(MSC)) u_lps_fsm (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .apm_en_i(apm_en_i), .an_en_i(an_en_i), .link_up_i(link_up_i), .energy_i(energy_i),
    .sleep_sel_i(sleep_sel_i), .wake_sel_i(wake_sel_i), .tmo_sel_hi_i(tmo_sel_hi_i),
    .tmo_sel_lo_i(tmo_sel_lo_i), .pwr_down_i(pwr_down_i), .state_o(state_o),
    .blocks_pd_o(blocks_pd_o), .mgmt_on_o(mgmt_on_o), .flp_burst_o(flp_burst_o),
    .flp_pair_b_o(flp_pair_b_o));

  lps_partner u_lps_partner (.clk_i(clk_i), .burst_i(flp_burst_o), .present_i(present),
    .energy_o(energy_i), .link_up_o(link_up_i));

  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic fail_at(input logic [31:0] g, input logic [31:0] e);
    err_count++;
    $display("wrong value at %0t ns: got %0h expected %0h", $time, g, e);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_st(input lps_state_t s, input int lim, output int n);
    n = 0;
    while (state_o !== s) begin
      tick(1);
      n++;
      if (n > lim) begin
        err_count++;
        report_and_stop();
      end
    end
  endtask

  task automatic t_cycle();
    int n;
    int b;
    logic [2:0] pr;
    wait_st(LPS_WAKE, 8100, n);
    `CHK(n inside {[7990:8010]}, 1'b1)
    `CHK(flp_burst_o, 1'b1)
    `CHK(mgmt_on_o, 1'b1)
    `CHK(blocks_pd_o, 1'b0)
    b = 1;
    pr = {2'b00, flp_pair_b_o};
    n = 0;
    while (state_o === LPS_WAKE && n < 500) begin
      tick(1);
      n++;
      if (flp_burst_o === 1'b1) begin
        b++;
        pr = {pr[1:0], flp_pair_b_o};
      end
    end
    `CHK(b, 3)
    `CHK(pr, 3'b010)
    `CHK(n inside {[392:408]}, 1'b1)
    `CHK(state_o, LPS_LOW)
    `CHK(blocks_pd_o, 1'b1)
    wait_st(LPS_WAKE, 4300, n);
    `CHK(n inside {[3670:4250]}, 1'b1)
  endtask

  task automatic t_energy();
    int n;
    @(posedge clk_i);
    present <= 1'b1;
    n = 0;
    while (energy_i !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    `CHK(energy_i, 1'b1)
    wait_st(LPS_NORMAL, 4, n);
    `CHK(blocks_pd_o, 1'b0)
  endtask

  task automatic t_timeout();
    int n;
    @(posedge clk_i);
    {tmo_sel_hi_i, tmo_sel_lo_i} <= 2'b01;
    sleep_sel_i <= 2'h1;
    tick(8);
    @(posedge clk_i);
    present <= 1'b0;
    wait_st(LPS_LOW, 4100, n);
    `CHK(n inside {[3990:4012]}, 1'b1)
  endtask

  task automatic t_an_off();
    int n;
    @(posedge clk_i);
    present <= 1'b1;
    wait_st(LPS_NORMAL, 9000, n);
    `CHK(n inside {[7670:8260]}, 1'b1)
    @(posedge clk_i);
    an_en_i <= 1'b0;
    tick(2);
    @(posedge clk_i);
    present <= 1'b0;
    tick(4400);
    `CHK(state_o, LPS_NORMAL)
    @(posedge clk_i);
    apm_en_i <= 1'b0;
    wait_st(LPS_OFF, 3, n);
    @(posedge clk_i);
    an_en_i <= 1'b1;
    apm_en_i <= 1'b1;
    wait_st(LPS_NORMAL, 3, n);
    wait_st(LPS_LOW, 4100, n);
    `CHK(n inside {[3990:4012]}, 1'b1)
  endtask

  task automatic t_forced();
    int n;
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    an_en_i <= 1'b0;
    tick(2);
    `CHK(state_o, LPS_LOW)
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    present <= 1'b1;
    wait_st(LPS_WAKE, 8100, n);
    wait_st(LPS_NORMAL, 20, n);
    @(posedge clk_i);
    pwr_down_i <= 1'b1;
    tick(2);
    `CHK(blocks_pd_o, 1'b1)
    @(posedge clk_i);
    pwr_down_i <= 1'b0;
    present <= 1'b0;
    tick(4400);
    `CHK(blocks_pd_o, 1'b0)
    `CHK(state_o, LPS_NORMAL)
  endtask

  initial begin
    tick(15);
    `CHK(state_o, LPS_LOW)
    `CHK(blocks_pd_o, 1'b1)
    `CHK(mgmt_on_o, 1'b1)
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    t_cycle();
    t_energy();
    t_timeout();
    t_an_off();
    t_forced();
    report_and_stop();
  end
endmodule
